// ==== ucd_defs.svh ====
// constants for the charger-detection link controller
`ifndef UCD_DEFS_SVH
`define UCD_DEFS_SVH

// transceiver register map, 6-bit immediate addresses
`define UCD_ADDR_FUNC_CTRL   6'h04
`define UCD_ADDR_FUNC_CLR    6'h06
`define UCD_ADDR_OTG_SET     6'h0b
`define UCD_ADDR_INT_STAT    6'h13
`define UCD_ADDR_DEBUG       6'h15
`define UCD_ADDR_IOPM_SET    6'h3a
`define UCD_ADDR_RID         6'h36

// transceiver register values
`define UCD_FUNC_CTRL_PREP   8'h49
`define UCD_FUNC_SUSPENDM    8'h40
`define UCD_OTG_ID_PULL      8'h01
`define UCD_IOPM_PULL_POS    8'h10
`define UCD_IOPM_PULL_NEG    8'h20
`define UCD_RID_GO           8'h10
`define UCD_INT_ID_GND_BIT   4
`define UCD_RID_DONE_BIT     3
`define UCD_RID_CHARGER      3'h2
`define UCD_IDLE_BYTE        8'h00

// link command and receive-command layout
`define UCD_TXCMD_WRITE      2'h2
`define UCD_TXCMD_READ       2'h3
`define UCD_RXCMD_VBUS_HI    3
`define UCD_RXCMD_VBUS_LO    2
`define UCD_VBUS_SESS_VALID  2'h2
`define UCD_LP_INT_BIT       3
`define UCD_LINE_SE0         2'h0
`define UCD_LINE_SE1         2'h3

// timing
`define UCD_CLK_NS           5
`define UCD_RID_CONV_NS      282000

// apb register offsets
`define UCD_APB_CTRL         8'h00
`define UCD_APB_STATUS       8'h04
`define UCD_APB_IRQ_STAT     8'h08
`define UCD_APB_IRQ_MASK     8'h0c

// control register bits
`define UCD_CTRL_START_ID    0
`define UCD_CTRL_START_SHORT 1
`define UCD_CTRL_SLEEP       2
`define UCD_CTRL_ABORT       3

// interrupt bits
`define UCD_IRQ_DONE         0
`define UCD_IRQ_PHY          1

`endif

// ==== ucd_pkg.sv ====
// types for the charger-detection link controller
package ucd_pkg;

    typedef enum logic [3:0] {
        S_IDLE    = 4'b0000,
        S_IDG     = 4'b0001,
        S_IDPU    = 4'b0010,
        S_RIDGO   = 4'b0011,
        S_RIDWAIT = 4'b0100,
        S_RIDPOLL = 4'b0101,
        S_SESS    = 4'b0110,
        S_FUNC    = 4'b0111,
        S_PUDP    = 4'b1000,
        S_PUDM    = 4'b1001,
        S_EVAL    = 4'b1010,
        S_SLEEP   = 4'b1011,
        S_LP      = 4'b1100,
        S_LPEXIT  = 4'b1101,
        S_LPREAD  = 4'b1110
    } ucd_seq_t;

    typedef enum logic [2:0] {
        P_IDLE  = 3'b000,
        P_CMD   = 3'b001,
        P_WDATA = 3'b010,
        P_STP   = 3'b011,
        P_TURN  = 3'b100,
        P_RDATA = 3'b101,
        P_FREE  = 3'b110
    } ucd_port_t;

    typedef enum logic [1:0] {
        RES_NONE    = 2'b00,
        RES_CHARGER = 2'b01,
        RES_HOST    = 2'b10,
        RES_UNDET   = 2'b11
    } ucd_result_t;

    typedef struct packed {
        logic       dir;
        logic       nxt;
        logic [7:0] data;
    } ucd_pin_in_t;

    typedef struct packed {
        logic [7:0] data;
        logic       data_oe_n;
        logic       stp;
    } ucd_pin_out_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ucd_apb_req_t;

    typedef struct packed {
        ucd_seq_t    seq;
        ucd_port_t   port;
        logic [9:0]  s1;
        logic [9:0]  s2;
        logic [9:0]  s3;
        logic [9:0]  filt;
        logic        dir_prev;
        logic        lp_int_prev;
        logic [7:0]  txd;
        logic        drive;
        logic        stp;
        logic        op_busy;
        logic        op_done;
        logic        op_read;
        logic [5:0]  op_addr;
        logic [7:0]  op_wdata;
        logic [7:0]  rdata;
        logic [16:0] cnt;
        ucd_result_t result;
        logic        res_valid;
        logic [2:0]  rid_code;
        logic        lowpower;
        logic        sess;
        logic [1:0]  line;
        logic [7:0]  int_src;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [31:0] prdata;
        logic        pslverr;
    } ucd_state_t;

endpackage

// ==== ucd_charger_detect.sv ====
// link-side charger-detection sequencer driving the transceiver pins
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ucd_defs.svh"

module ucd_charger_detect
    import ucd_pkg::*;
#(
    parameter int RID_WAIT_CYC = `UCD_RID_CONV_NS / `UCD_CLK_NS,
    parameter logic [5:0] RID_ADDR = `UCD_ADDR_RID
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire ucd_apb_req_t apb_req,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire ucd_pin_in_t  pin_in,
    output ucd_pin_out_t      pin_out,
    output logic              irq,
    output ucd_result_t       result,
    output logic              result_valid
);

    ucd_state_t r_reg;
    ucd_state_t r_next;

    // queue one transceiver register access for the port engine
    function automatic ucd_state_t issue(input ucd_state_t s,
                                         input logic [5:0] addr,
                                         input logic [7:0] data,
                                         input logic rd);
        ucd_state_t t;
        t = s;
        t.op_busy  = 1'b1;
        t.op_addr  = addr;
        t.op_wdata = data;
        t.op_read  = rd;
        return t;
    endfunction

    // an access may start once the previous one is fully retired
    function automatic logic op_free(input ucd_state_t s);
        return !s.op_busy && !s.op_done;
    endfunction

    // finish a procedure with a single reported outcome
    function automatic ucd_state_t finish(input ucd_state_t s,
                                          input ucd_result_t res);
        ucd_state_t t;
        t = s;
        t.result    = res;
        t.res_valid = 1'b1;
        t.seq       = S_IDLE;
        t.irq_stat[`UCD_IRQ_DONE] = 1'b1;
        return t;
    endfunction

    logic        dir;
    logic        nxt;
    logic [7:0]  din;
    logic        apb_setup;
    logic        apb_wr;
    logic [31:0] status_word;
    logic [1:0]  w1c;
    logic [1:0]  irq_set;

    assign dir = r_reg.filt[9];
    assign nxt = r_reg.filt[8];
    assign din = r_reg.filt[7:0];

    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;

    assign status_word = {8'h00, r_reg.int_src, 3'h0, r_reg.sess,
                          r_reg.line, r_reg.lowpower,
                          r_reg.seq != S_IDLE, 3'h0, r_reg.rid_code,
                          r_reg.result};

    always_comb begin
        r_next = r_reg;
        r_next.op_done   = 1'b0;
        r_next.res_valid = 1'b0;
        irq_set = 2'h0;
        w1c     = 2'h0;

        // pins: three stages, accept a bit once stages two and three agree
        r_next.s1 = {pin_in.dir, pin_in.nxt, pin_in.data};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.filt = (r_reg.filt & (r_reg.s2 ^ r_reg.s3))
                    | (r_reg.s3 & ~(r_reg.s2 ^ r_reg.s3));
        r_next.dir_prev = dir;

        if (!r_reg.lowpower && dir && r_reg.dir_prev && !nxt
            && r_reg.port == P_IDLE) begin
            r_next.sess = din[`UCD_RXCMD_VBUS_HI:`UCD_RXCMD_VBUS_LO]
                          >= `UCD_VBUS_SESS_VALID;
            r_next.line = din[1:0];
        end

        // ---------------- port engine ----------------
        r_next.drive = !dir;
        case (r_reg.port)
            P_IDLE: begin
                r_next.txd = `UCD_IDLE_BYTE;
                if (r_reg.op_busy && !dir && !r_reg.lowpower) begin
                    r_next.txd = {r_reg.op_read ? `UCD_TXCMD_READ
                                                : `UCD_TXCMD_WRITE,
                                  r_reg.op_addr};
                    r_next.port = P_CMD;
                end
            end
            P_CMD: begin
                if (dir) begin
                    // transceiver took the bus; retry afterwards
                    r_next.txd  = `UCD_IDLE_BYTE;
                    r_next.port = P_IDLE;
                end else if (nxt) begin
                    if (r_reg.op_read) begin
                        r_next.drive = 1'b0;
                        r_next.port  = P_TURN;
                    end else begin
                        r_next.txd  = r_reg.op_wdata;
                        r_next.port = P_WDATA;
                    end
                end
            end
            P_WDATA: begin
                if (nxt) begin
                    r_next.stp  = 1'b1;
                    r_next.txd  = `UCD_IDLE_BYTE;
                    r_next.port = P_STP;
                end
            end
            P_STP: begin
                r_next.stp = 1'b0;
                // nxt lags the pins; a stale one would fake the next accept
                if (!nxt) begin
                    r_next.op_busy = 1'b0;
                    r_next.op_done = 1'b1;
                    r_next.port    = P_IDLE;
                end
            end
            P_TURN: begin
                r_next.drive = 1'b0;
                r_next.txd   = `UCD_IDLE_BYTE;
                if (dir) begin
                    r_next.port = P_RDATA;
                end
            end
            P_RDATA: begin
                r_next.drive = 1'b0;
                r_next.rdata = din;
                r_next.port  = P_FREE;
            end
            P_FREE: begin
                if (!dir) begin
                    r_next.op_busy = 1'b0;
                    r_next.op_done = 1'b1;
                    r_next.port    = P_IDLE;
                end
            end
            default: begin
                r_next.port = P_IDLE;
            end
        endcase

        // ---------------- sequencer ----------------
        case (r_reg.seq)
            S_IDLE: begin
                r_next.cnt = 17'h0;
            end
            S_IDG: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_INT_STAT, 8'h00, 1'b1);
                end else if (r_reg.op_done
                             && r_reg.rdata[`UCD_INT_ID_GND_BIT]) begin
                    r_next.seq = S_IDPU;
                end
            end
            S_IDPU: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_OTG_SET,
                                   `UCD_OTG_ID_PULL, 1'b0);
                end else if (r_reg.op_done) begin
                    r_next.seq = S_RIDGO;
                end
            end
            S_RIDGO: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, RID_ADDR, `UCD_RID_GO, 1'b0);
                end else if (r_reg.op_done) begin
                    r_next.cnt = 17'h0;
                    r_next.seq = S_RIDWAIT;
                end
            end
            // no poll before the conversion time
            S_RIDWAIT: begin
                r_next.cnt = r_reg.cnt + 17'h1;
                if (r_reg.cnt >= 17'(RID_WAIT_CYC - 1)) begin
                    r_next.seq = S_RIDPOLL;
                end
            end
            // finished flag and code come in one read; only the go write clears the flag
            S_RIDPOLL: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, RID_ADDR, 8'h00, 1'b1);
                end else if (r_reg.op_done
                             && r_reg.rdata[`UCD_RID_DONE_BIT]) begin
                    r_next.rid_code = r_reg.rdata[2:0];
                    r_next = finish(r_next,
                                    r_reg.rdata[2:0] == `UCD_RID_CHARGER
                                    ? RES_CHARGER : RES_UNDET);
                end
            end
            S_SESS: begin
                if (r_reg.sess) begin
                    r_next.seq = S_FUNC;
                end
            end
            S_FUNC: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_FUNC_CTRL,
                                   `UCD_FUNC_CTRL_PREP, 1'b0);
                end else if (r_reg.op_done) begin
                    r_next.seq = S_PUDP;
                end
            end
            S_PUDP: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_IOPM_SET,
                                   `UCD_IOPM_PULL_POS, 1'b0);
                end else if (r_reg.op_done) begin
                    r_next.seq = S_PUDM;
                end
            end
            // negative pull set on its own
            S_PUDM: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_IOPM_SET,
                                   `UCD_IOPM_PULL_NEG, 1'b0);
                end else if (r_reg.op_done) begin
                    r_next.seq = S_EVAL;
                end
            end
            S_EVAL: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_DEBUG, 8'h00, 1'b1);
                end else if (r_reg.op_done) begin
                    r_next.line = r_reg.rdata[1:0];
                    if (r_reg.rdata[1:0] == `UCD_LINE_SE1) begin
                        r_next = finish(r_next, RES_CHARGER);
                    end else if (r_reg.rdata[1:0] == `UCD_LINE_SE0) begin
                        r_next = finish(r_next, RES_HOST);
                    end else begin
                        r_next = finish(r_next, RES_UNDET);
                    end
                end
            end
            S_SLEEP: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_FUNC_CLR,
                                   `UCD_FUNC_SUSPENDM, 1'b0);
                end else if (r_reg.op_done) begin
                    r_next.lowpower    = 1'b1;
                    r_next.lp_int_prev = 1'b1;
                    r_next.seq         = S_LP;
                end
            end
            S_LP: begin
                if (dir) begin
                    // line state on data 0 and 1
                    r_next.line = din[1:0];
                    r_next.lp_int_prev = din[`UCD_LP_INT_BIT];
                    if (din[`UCD_LP_INT_BIT] && !r_reg.lp_int_prev) begin
                        r_next.stp = 1'b1;
                        r_next.seq = S_LPEXIT;
                    end
                end
            end
            // stop held until the transceiver releases the bus
            S_LPEXIT: begin
                r_next.stp = 1'b1;
                if (!dir) begin
                    r_next.stp      = 1'b0;
                    r_next.lowpower = 1'b0;
                    r_next.seq      = S_LPREAD;
                end
            end
            S_LPREAD: begin
                if (op_free(r_reg)) begin
                    r_next = issue(r_next, `UCD_ADDR_INT_STAT, 8'h00, 1'b1);
                end else if (r_reg.op_done) begin
                    r_next.int_src = r_reg.rdata;
                    irq_set[`UCD_IRQ_PHY] = 1'b1;
                    r_next.seq = S_IDLE;
                end
            end
            default: begin
                r_next.seq = S_IDLE;
            end
        endcase

        // ---------------- apb slave ----------------
        if (apb_setup) begin
            r_next.pslverr = 1'b0;
            case (apb_req.paddr)
                `UCD_APB_CTRL:     r_next.prdata = 32'h0;
                `UCD_APB_STATUS:   r_next.prdata = status_word;
                `UCD_APB_IRQ_STAT: r_next.prdata = {30'h0, r_reg.irq_stat};
                `UCD_APB_IRQ_MASK: r_next.prdata = {30'h0, r_reg.irq_mask};
                default: begin
                    r_next.prdata  = 32'h0;
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_wr) begin
            case (apb_req.paddr)
                `UCD_APB_CTRL: begin
                    if (apb_req.pwdata[`UCD_CTRL_ABORT]
                        && r_reg.seq != S_LP && r_reg.seq != S_LPEXIT) begin
                        // in-flight access still retires on the pins
                        r_next.seq = S_IDLE;
                    end else if (r_reg.seq == S_IDLE) begin
                        if (apb_req.pwdata[`UCD_CTRL_START_ID]) begin
                            r_next.seq = S_IDG;
                        end else if (apb_req.pwdata[`UCD_CTRL_START_SHORT])
                        begin
                            r_next.seq = S_SESS;
                        end else if (apb_req.pwdata[`UCD_CTRL_SLEEP]) begin
                            r_next.seq = S_SLEEP;
                        end
                    end
                end
                `UCD_APB_IRQ_STAT: w1c = apb_req.pwdata[1:0];
                `UCD_APB_IRQ_MASK: r_next.irq_mask = apb_req.pwdata[1:0];
                default: begin
                end
            endcase
        end
        // a new event outranks a clear in the same cycle
        r_next.irq_stat = (r_next.irq_stat & ~w1c) | irq_set;
        if (r_next.res_valid) begin
            r_next.irq_stat[`UCD_IRQ_DONE] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign pready            = 1'b1;
    assign prdata            = r_reg.prdata;
    assign pslverr           = r_reg.pslverr;
    assign pin_out.data      = r_reg.txd;
    assign pin_out.data_oe_n = !r_reg.drive;
    assign pin_out.stp       = r_reg.stp;
    assign irq               = |(r_reg.irq_stat & r_reg.irq_mask);
    assign result            = r_reg.result;
    assign result_valid      = r_reg.res_valid;

endmodule

// ==== ucd_charger_detect_props.sv ====
// port assertions for the charger-detection link controller
`timescale 1ns/1ps
`include "ucd_defs.svh"
module ucd_charger_detect_props
    import ucd_pkg::*;
(
    input wire logic         clk,
    input wire logic         resetn,
    input wire logic         ce,
    input wire ucd_apb_req_t apb_req,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire ucd_pin_in_t  pin_in,
    input wire ucd_pin_out_t pin_out,
    input wire logic         irq,
    input wire ucd_result_t  result,
    input wire logic         result_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // command byte held, then the first byte that follows it
    sequence s_cmd(logic [7:0] c);
        !pin_out.data_oe_n && pin_out.data == c
        ##1 !pin_out.data_oe_n && pin_out.data != c;
    endsequence
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    property p_func;
        s_cmd(8'h84) |-> pin_out.data == `UCD_FUNC_CTRL_PREP;
    endproperty
    a_func: assert property (p_func)
        else $error("function control byte wrong");
    property p_iopm;
        s_cmd(8'hba) |-> pin_out.data inside {8'h10, 8'h20};
    endproperty
    a_iopm: assert property (p_iopm)
        else $error("pull set byte wrong");
    // a link driving against the transceiver would corrupt line samples
    property p_oe;
        pin_in.dir [*8] |-> pin_out.data_oe_n;
    endproperty
    a_oe: assert property (p_oe)
        else $error("link drives while dir high");
    property p_lpx;
        pin_out.stp && pin_in.dir |=> pin_out.stp;
    endproperty
    a_lpx: assert property (p_lpx)
        else $error("stop dropped before dir low");
    property p_rv;
        result_valid |-> result != RES_NONE ##1 !result_valid;
    endproperty
    a_rv: assert property (p_rv)
        else $error("result pulse wrong");
    property p_err;
        s_setup and !(apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})
            |=> pslverr;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access without error");
    property p_ctrl0;
        s_setup and !apb_req.pwrite && apb_req.paddr == 8'h00
            |=> prdata == 32'h0;
    endproperty
    a_ctrl0: assert property (p_ctrl0)
        else $error("control reads nonzero");
    property p_mask;
        apb_req.psel && apb_req.penable && apb_req.pwrite
            && apb_req.paddr == 8'h0c && apb_req.pwdata[1:0] == 2'h0
            |=> !irq;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked interrupt still high");
endmodule
bind ucd_charger_detect ucd_charger_detect_props i_ucd_charger_detect_props (
    .clk(clk), .resetn(resetn), .ce(ce), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .irq(irq), .result(result), .result_valid(result_valid));

// ==== ucd_phy_model.sv ====
// transceiver model: register port, id converter, line state, low power
`timescale 1ns/1ps
module ucd_phy_model
    import ucd_pkg::*;
#(
    parameter int RID_CYC = 15
) (
    input  wire logic         clk,
    input  wire ucd_pin_out_t po,
    output ucd_pin_in_t       pi,
    input  wire logic         id_gnd,
    input  wire logic [2:0]   rid_val,
    input  wire logic         shorted,
    input  wire logic         rx_go,
    input  wire logic         wake
);
    logic [7:0] cmd = 0, wd = 0, pd = 0, last = 0, fctl = 0, otg = 0, w;
    logic [1:0] pulls = 0, line;
    logic       dir = 0, nxt = 0, lp = 0;
    int         cnt = 0, rcnt = 0, nwr = 0;
    assign line = (pulls == 2'h3) ? {2{shorted}} : 2'h1;
    // released bus shows a changing level, never a stale one
    assign w = dir ? pd : (!po.data_oe_n ? po.data : ~last);
    assign pi = {dir, nxt, w};
    // three-bit code, done after the conversion time
    function automatic logic [7:0] rd(input logic [5:0] a);
        case (a)
            6'h13: rd = {3'h0, id_gnd, 4'h0};
            6'h36: rd = {4'h0, rcnt == 0, rid_val};
            6'h15: rd = {6'h0, line};
            default: rd = 8'h00;
        endcase
    endfunction
    always @(posedge clk) begin
        last <= w;
        if (rcnt > 0)
            rcnt <= rcnt - 1;
        if (cnt > 0) begin
            cnt <= cnt - 1;
            dir <= cnt > 1;
        end else if (lp) begin
            // line state on data 0 and 1 in low power
            pd <= {4'h0, wake, 1'b0, line};
            if (po.stp) begin
                lp <= 1'b0;
                dir <= 1'b0;
            end
        end else if (!nxt) begin
            if (rx_go) begin
                dir <= 1'b1;
                pd <= {4'h0, 2'h2, line};
                cnt <= 6;
            end else if (!po.data_oe_n && po.data[7]) begin
                nxt <= 1'b1;
                cmd <= po.data;
            end
        end else if (cmd[6]) begin
            if (po.data_oe_n) begin
                nxt <= 1'b0;
                dir <= 1'b1;
                pd <= rd(cmd[5:0]);
                cnt <= 8;
            end
        end else if (po.stp) begin
            nxt <= 1'b0;
            nwr <= nwr + 1;
            case (cmd[5:0])
                6'h04: fctl <= wd;
                // low power: dir held high, data shows line and interrupt
                6'h06: begin
                    lp  <= wd[6];
                    dir <= wd[6];
                end
                6'h0b: otg <= wd;
                6'h36: rcnt <= RID_CYC;
                // set address ORs in the pulls on data bits 5 and 4, never removes one
                6'h3a: pulls <= pulls | wd[5:4];
                default: ;
            endcase
        end else if (w != cmd) begin
            wd <= w;
        end
    end
endmodule

// ==== ucd_charger_detect_tb.sv ====
// self-checking bench for the charger-detection link controller
`timescale 1ns/1ps
`include "ucd_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module ucd_charger_detect_tb
    import ucd_pkg::*;
;
    logic         clk = 0, resetn = 0, pready, pslverr, irq, rv, err;
    logic         id_gnd = 0, shorted = 0, rx_go = 0, wake = 0, ce = 1;
    logic [2:0]   rid_val = 3'h2;
    logic [1:0]   msk = 0;
    logic [31:0]  prdata, rd;
    ucd_apb_req_t req = '0;
    ucd_pin_in_t  pi;
    ucd_pin_out_t po;
    ucd_result_t  result;
    int           fail_count = 0, total_checks = 0, cyc = 0;
    always #2.5 clk = ~clk;
    ucd_charger_detect #(.RID_WAIT_CYC(20)) i_ucd_charger_detect (
        .clk(clk), .resetn(resetn), .ce(ce), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pi), .pin_out(po),
        .irq(irq), .result(result), .result_valid(rv));
    ucd_phy_model #(.RID_CYC(15)) i_ucd_phy_model (.clk(clk), .po(po),
        .pi(pi), .id_gnd(id_gnd), .rid_val(rid_val), .shorted(shorted),
        .rx_go(rx_go), .wake(wake));
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        // no wait count assumed; only the bench ceiling ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wait_res(input ucd_result_t e);
        for (int n = 0; n < 3000 && rv !== 1'b1; n++) @(posedge clk);
        `CHK("done", 1'b1, rv)
        `CHK("result", e, result)
        repeat (2) @(posedge clk);
        `CHK("irq", msk[0], irq)
        apb(1, `UCD_APB_IRQ_STAT, 32'h1);
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ceiling well above the several hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        int n0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        apb(0, `UCD_APB_STATUS, 0);
        `CHK("status", 32'h0, rd)
        apb(0, 8'h10, 0);
        `CHK("unmapped", 1'b1, err)
        apb(1, `UCD_APB_IRQ_MASK, 32'h0);
        // clock enable low: this write must not land
        ce <= 1'b0;
        apb(1, `UCD_APB_IRQ_MASK, 32'h3);
        ce <= 1'b1;
        apb(0, `UCD_APB_IRQ_MASK, 0);
        `CHK("frozen mask", 32'h0, rd)
        apb(0, `UCD_APB_CTRL, 0);
        `CHK("ctrl", 32'h0, rd)
        $display("test registers done");
        apb(1, `UCD_APB_CTRL, 32'h1);
        repeat (60) @(posedge clk);
        apb(0, `UCD_APB_STATUS, 0);
        `CHK("busy", 1'b1, rd[8])
        `CHK("pull early", 8'h00, i_ucd_phy_model.otg)
        apb(1, `UCD_APB_CTRL, 32'h8);
        apb(0, `UCD_APB_STATUS, 0);
        `CHK("aborted", 1'b0, rd[8])
        apb(1, `UCD_APB_CTRL, 32'h1);
        id_gnd <= 1'b1;
        wait_res(RES_CHARGER);
        `CHK("id pull", 8'h01, i_ucd_phy_model.otg)
        msk = 2'h3;
        apb(1, `UCD_APB_IRQ_MASK, 32'h3);
        rid_val <= 3'h5;
        apb(1, `UCD_APB_CTRL, 32'h1);
        wait_res(RES_UNDET);
        apb(0, `UCD_APB_STATUS, 0);
        `CHK("rid code", 3'h5, rd[4:2])
        $display("test id check done");
        for (int k = 0; k < 2; k++) begin
            if (k) begin
                // reset forgets the session; mask comes back cleared
                resetn <= 1'b0;
                @(posedge clk);
                resetn <= 1'b1;
                apb(1, `UCD_APB_IRQ_MASK, 32'h3);
            end
            shorted <= (k == 0);
            n0 = i_ucd_phy_model.nwr;
            apb(1, `UCD_APB_CTRL, 32'h2);
            repeat (40) @(posedge clk);
            `CHK("early writes", n0, i_ucd_phy_model.nwr)
            rx_go <= 1'b1;
            @(posedge clk);
            rx_go <= 1'b0;
            wait_res(k ? RES_HOST : RES_CHARGER);
            `CHK("func ctrl", 8'h49, i_ucd_phy_model.fctl)
            `CHK("pulls", 2'h3, i_ucd_phy_model.pulls)
            `CHK("writes", n0 + 3, i_ucd_phy_model.nwr)
        end
        $display("test short done");
        shorted <= 1'b1;
        apb(1, `UCD_APB_CTRL, 32'h4);
        repeat (60) @(posedge clk);
        apb(0, `UCD_APB_STATUS, 0);
        `CHK("low power", 1'b1, rd[9])
        `CHK("line", 2'h3, rd[11:10])
        wake <= 1'b1;
        for (int n = 0; n < 500 && irq !== 1'b1; n++) @(posedge clk);
        `CHK("phy irq", 1'b1, irq)
        apb(0, `UCD_APB_STATUS, 0);
        `CHK("int source", 8'h10, rd[23:16])
        `CHK("awake", 1'b0, rd[9])
        apb(0, `UCD_APB_IRQ_STAT, 0);
        `CHK("irq stat", 2'h2, rd[1:0])
        $display("test low power done");
        stop_test();
    end
endmodule
